// ---- pkg/pwo_map.svh ----
// Purpose: register offsets, field positions, reset values of the stage
// Assumes: byte addresses on a 32-bit Avalon-MM slave
// Notes:   definitions only
`ifndef PWO_MAP_SVH
`define PWO_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PWO_OFS_AUX_SEL   8'h48
`define PWO_OFS_FORCE     8'h4c
`define PWO_OFS_ACT_A     8'h50
`define PWO_OFS_ACT_B     8'h54
`define PWO_OFS_DT_CTRL   8'h58
`define PWO_OFS_FALL_SH   8'h5c
`define PWO_OFS_RISE_SH   8'h60
`define PWO_OFS_CARRIER   8'h64
`define PWO_OFS_STATUS    8'h70
`define PWO_OFS_DLY_ACT   8'h74

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PWO_F_HOLD_SEL    5:0
`define PWO_F_HOLD_MODE   9:6
`define PWO_F_TRIG_A      10
`define PWO_F_OS_MODE_A   12:11
`define PWO_F_TRIG_B      13
`define PWO_F_OS_MODE_B   15:14
`define PWO_F_FALL_SEL    3:0
`define PWO_F_RISE_SEL    7:4
`define PWO_F_DUAL_B      8
`define PWO_F_EXCH_A      9
`define PWO_F_EXCH_B      10
`define PWO_F_RISE_SRC    11
`define PWO_F_FALL_SRC    12
`define PWO_F_RISE_POL    13
`define PWO_F_FALL_POL    14
`define PWO_F_SKIP_A      15
`define PWO_F_SKIP_B      16
`define PWO_F_DT_CLK      17
`define PWO_F_CH_EN       0
`define PWO_F_CH_DIV      4:1
`define PWO_F_CH_DUTY     7:5
`define PWO_F_CH_FIRST    11:8
`define PWO_F_CH_OPOL     12
`define PWO_F_CH_IPOL     13

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define PWO_RST_WORD      32'h0000_0000
`define PWO_DLY_W         16
`define PWO_DUTY_STEPS    3'h7

`endif

// ---- pkg/pwo_pkg.sv ----
// Purpose: types shared by the operator output stage
// Assumes: pwo_map.svh gives the widths
// Notes:   whole block state lives in one packed struct
`include "pwo_map.svh"

package pwo_pkg;

  typedef enum logic [1:0] {
    PWO_ACT_KEEP   = 2'b00,
    PWO_ACT_LOW    = 2'b01,
    PWO_ACT_HIGH   = 2'b10,
    PWO_ACT_TOGGLE = 2'b11
  } pwo_act_e;

  typedef struct packed {
    logic t1;
    logic t0;
    logic match_b;
    logic match_a;
    logic period;
    logic zero;
  } pwo_evt_s;

  typedef struct packed {
    logic [5:0]             aux_sel;
    logic [15:0]            force_ctl;
    logic [23:0]            act_a;
    logic [23:0]            act_b;
    logic [17:0]            dt_ctl;
    logic [`PWO_DLY_W-1:0]  fall_sh;
    logic [`PWO_DLY_W-1:0]  rise_sh;
    logic [13:0]            car_ctl;
    logic [3:0]             hold_act;
    logic [`PWO_DLY_W-1:0]  rise_act;
    logic [`PWO_DLY_W-1:0]  fall_act;
    logic [1:0]             trig_prev;
    logic [1:0]             gen;
    logic [`PWO_DLY_W-1:0]  rise_cnt;
    logic [`PWO_DLY_W-1:0]  fall_cnt;
    logic [3:0]             div_cnt;
    logic [2:0]             phase;
    logic [3:0]             first_a;
    logic [3:0]             first_b;
    logic [1:0]             outp;
    logic                   ack;
    logic [31:0]            rdata;
  } pwo_state_s;

endpackage

// ---- design/pwo_output_stage.sv ----
// Purpose: output stage of one PWM operator: force, action table,
//          dead time and carrier chopper, with Avalon-MM registers
// Assumes: timer value, compare values, sync and faults come from
//          logic on ref_clk; timer_tick_en marks each timer step
// Notes:   one wait state on every bus access
//
// Behaviour
// - one-shot force mode: 1 low, 2 high
// - trigger bit toggle fires one force
// - continuous force mode: 1 low, 2 high
// - continuous force loads per six-bit update select
// - match events when timer equals compare value
// - action codes: keep, low, high, toggle
// - up count uses six up actions
// - down count uses six separate actions
// - output B has its own table
// - dead time counts module or tick clock
// - dual-edge mode puts both delays on B
// - rise delay loads per four-bit update select
// - fall delay loads with same select coding
// - delay writes land in shadow copies
// - carrier input invert on both outputs
// - carrier output invert on both outputs
// - first chopped pulse lasts configured carrier clock ticks
// - carrier duty is field over eight
// - carrier period is eight times clock times div plus one
// - carrier disabled passes outputs unchanged
// - aux events pick fault, sync or none
// - period event when timer equals period
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "pwo_map.svh"

module pwo_output_stage
  import pwo_pkg::*;
#(
  parameter int TMR_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              timer_tick_en,
  input  wire logic              timer_dir,
  input  wire logic [TMR_W-1:0]  timer_value,
  input  wire logic [TMR_W-1:0]  timer_period,
  input  wire logic [TMR_W-1:0]  cmp_a_value,
  input  wire logic [TMR_W-1:0]  cmp_b_value,
  input  wire logic              evt_sync,
  input  wire logic              fault_input_0,
  input  wire logic              fault_input_1,
  input  wire logic              fault_input_2,
  output logic                   out_a,
  output logic                   out_b
);

  // --------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------
  // update select: zero loads at once, top bit blocks, else any selected event
  function automatic logic upd_hit(input logic [5:0] sel,
                                   input logic [4:0] ev);
    upd_hit = (sel == 6'h00) | (~sel[5] & (|(sel[4:0] & ev)));
  endfunction

  // four-bit delay select widened to the six-bit form
  function automatic logic [5:0] dly_sel(input logic [3:0] s);
    dly_sel = {s[3], s[2], 2'b00, s[1], s[0]};
  endfunction

  // aux source: 0..2 fault, 3 sync, others none
  function automatic logic aux_pick(input logic [2:0] code,
                                    input logic [2:0] flt,
                                    input logic       syn);
    unique case (code)
      3'h0:    aux_pick = flt[0];
      3'h1:    aux_pick = flt[1];
      3'h2:    aux_pick = flt[2];
      3'h3:    aux_pick = syn;
      default: aux_pick = 1'b0;
    endcase
  endfunction

  // one action field applied to a level
  function automatic logic act_apply(input logic [1:0] code,
                                     input logic       lvl);
    unique case (pwo_act_e'(code))
      PWO_ACT_KEEP:   act_apply = lvl;
      PWO_ACT_LOW:    act_apply = 1'b0;
      PWO_ACT_HIGH:   act_apply = 1'b1;
      PWO_ACT_TOGGLE: act_apply = ~lvl;
    endcase
  endfunction

  // walk the six events of one direction, later sources win
  function automatic logic gen_next(input logic [23:0] tbl,
                                    input logic       down,
                                    input pwo_evt_s   ev,
                                    input logic       lvl);
    logic [11:0] half;
    logic        res;
    half = down ? tbl[23:12] : tbl[11:0];
    res  = lvl;
    for (int k = 0; k < 6; k++) begin
      if (ev[k]) begin
        res = act_apply(half[2*k +: 2], lvl);
      end
    end
    gen_next = res;
  endfunction

  // byte-enable merge of a write into a register word
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    for (int k = 0; k < 4; k++) begin
      be_merge[8*k +: 8] = be[k] ? wd[8*k +: 8] : old[8*k +: 8];
    end
  endfunction

  // --------------------------------------------------------------------
  // state and events
  // --------------------------------------------------------------------
  pwo_state_s  st_q;
  pwo_state_s  st_d;
  pwo_evt_s    ev;
  logic [4:0]  upd_ev;
  logic [1:0]  os_fire;
  logic        dt_a;
  logic        dt_b;
  logic        ctick;
  logic [31:0] rd_word;

  // timer comparisons, one event per timer step
  assign ev.zero    = timer_tick_en & (timer_value == '0);
  assign ev.period  = timer_tick_en & (timer_value == timer_period);
  assign ev.match_a = timer_tick_en & (timer_value == cmp_a_value);
  assign ev.match_b = timer_tick_en & (timer_value == cmp_b_value);
  assign ev.t0 = aux_pick(st_q.aux_sel[2:0],
                          {fault_input_2, fault_input_1, fault_input_0},
                          evt_sync);
  assign ev.t1 = aux_pick(st_q.aux_sel[5:3],
                          {fault_input_2, fault_input_1, fault_input_0},
                          evt_sync);
  assign upd_ev = {evt_sync, ev.match_b, ev.match_a, ev.period, ev.zero};

  // trigger bit changes in either direction
  assign os_fire = {st_q.force_ctl[`PWO_F_TRIG_B],
                    st_q.force_ctl[`PWO_F_TRIG_A]} ^ st_q.trig_prev;

  // carrier clock enable from the prescaler
  assign ctick = st_q.car_ctl[`PWO_F_CH_EN] &
                 (st_q.div_cnt == st_q.car_ctl[`PWO_F_CH_DIV]);

  // --------------------------------------------------------------------
  // bus slave: one wait state, registered read data
  // --------------------------------------------------------------------
  always_comb begin
    unique case (avs_address)
      `PWO_OFS_AUX_SEL: rd_word = {26'h0, st_q.aux_sel};
      `PWO_OFS_FORCE:   rd_word = {16'h0, st_q.force_ctl};
      `PWO_OFS_ACT_A:   rd_word = {8'h0, st_q.act_a};
      `PWO_OFS_ACT_B:   rd_word = {8'h0, st_q.act_b};
      `PWO_OFS_DT_CTRL: rd_word = {14'h0, st_q.dt_ctl};
      `PWO_OFS_FALL_SH: rd_word = {16'h0, st_q.fall_sh};
      `PWO_OFS_RISE_SH: rd_word = {16'h0, st_q.rise_sh};
      `PWO_OFS_CARRIER: rd_word = {18'h0, st_q.car_ctl};
      `PWO_OFS_STATUS:  rd_word = {24'h0, st_q.hold_act, st_q.gen,
                                   st_q.outp};
      `PWO_OFS_DLY_ACT: rd_word = {st_q.rise_act, st_q.fall_act};
      default:          rd_word = `PWO_RST_WORD;
    endcase
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~st_q.ack;
  assign avs_readdata    = st_q.rdata;
  assign out_a           = st_q.outp[0];
  assign out_b           = st_q.outp[1];

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    logic [31:0] wm;
    logic [1:0]  lvl;
    logic [1:0]  hold;
    logic [1:0]  osm;
    logic        dt_clk_en;
    logic        rise_in;
    logic        rise_o;
    logic        fall_in;
    logic        fall_o;
    logic        path_a;
    logic        path_b;
    logic        cwave;
    logic        cin_a;
    logic        cin_b;
    logic        ch_a;
    logic        ch_b;
    wm        = be_merge(rd_word, avs_writedata, avs_byteenable);
    lvl       = 2'b00;
    hold      = 2'b00;
    osm       = 2'b00;
    dt_clk_en = 1'b0;
    rise_in   = 1'b0;
    rise_o    = 1'b0;
    fall_in   = 1'b0;
    fall_o    = 1'b0;
    path_a    = 1'b0;
    path_b    = 1'b0;
    cwave     = 1'b0;
    cin_a     = 1'b0;
    cin_b     = 1'b0;
    ch_a      = 1'b0;
    ch_b      = 1'b0;
    dt_a      = 1'b0;
    dt_b      = 1'b0;
    st_d      = st_q;

    // bus access: read captured on entry, write lands on the answer
    st_d.ack = (avs_read | avs_write) & ~st_q.ack;
    if (avs_read & ~st_q.ack) begin
      st_d.rdata = rd_word;
    end
    if (avs_write & st_q.ack) begin
      unique case (avs_address)
        `PWO_OFS_AUX_SEL: st_d.aux_sel   = wm[5:0];
        `PWO_OFS_FORCE:   st_d.force_ctl = wm[15:0];
        `PWO_OFS_ACT_A:   st_d.act_a     = wm[23:0];
        `PWO_OFS_ACT_B:   st_d.act_b     = wm[23:0];
        `PWO_OFS_DT_CTRL: st_d.dt_ctl    = wm[17:0];
        `PWO_OFS_FALL_SH: st_d.fall_sh   = wm[15:0];
        `PWO_OFS_RISE_SH: st_d.rise_sh   = wm[15:0];
        `PWO_OFS_CARRIER: st_d.car_ctl   = wm[13:0];
        default:          st_d.ack       = 1'b0;
      endcase
      st_d.ack = 1'b0;
    end

    // shadow transfers of continuous force and both delays
    if (upd_hit(st_q.force_ctl[`PWO_F_HOLD_SEL], upd_ev)) begin
      st_d.hold_act = st_q.force_ctl[`PWO_F_HOLD_MODE];
    end
    if (upd_hit(dly_sel(st_q.dt_ctl[`PWO_F_RISE_SEL]), upd_ev)) begin
      st_d.rise_act = st_q.rise_sh;
    end
    if (upd_hit(dly_sel(st_q.dt_ctl[`PWO_F_FALL_SEL]), upd_ev)) begin
      st_d.fall_act = st_q.fall_sh;
    end

    // action table per output, then the two kinds of force
    st_d.trig_prev = {st_q.force_ctl[`PWO_F_TRIG_B],
                      st_q.force_ctl[`PWO_F_TRIG_A]};
    lvl[0] = gen_next(st_q.act_a, timer_dir, ev, st_q.gen[0]);
    lvl[1] = gen_next(st_q.act_b, timer_dir, ev, st_q.gen[1]);
    for (int i = 0; i < 2; i++) begin
      hold = st_q.hold_act[2*i +: 2];
      osm  = (i == 0) ? st_q.force_ctl[`PWO_F_OS_MODE_A]
                      : st_q.force_ctl[`PWO_F_OS_MODE_B];
      if (hold == 2'b01 || hold == 2'b10) begin
        lvl[i] = hold[1];
      end else if (os_fire[i] && (osm == 2'b01 || osm == 2'b10)) begin
        lvl[i] = osm[1];
      end
    end
    st_d.gen = lvl;

    // dead time: rising edge delay then falling edge delay
    dt_clk_en = st_q.dt_ctl[`PWO_F_DT_CLK] ? timer_tick_en : 1'b1;
    rise_in = st_q.dt_ctl[`PWO_F_RISE_SRC] ? st_q.gen[1] : st_q.gen[0];
    if (!rise_in) begin
      st_d.rise_cnt = '0;
    end else if (dt_clk_en && st_q.rise_cnt < st_q.rise_act) begin
      st_d.rise_cnt = st_q.rise_cnt + 1'b1;
    end
    rise_o = (rise_in & (st_q.rise_cnt >= st_q.rise_act)) ^
             st_q.dt_ctl[`PWO_F_RISE_POL];
    if (st_q.dt_ctl[`PWO_F_DUAL_B]) begin
      fall_in = rise_o;
    end else begin
      fall_in = st_q.dt_ctl[`PWO_F_FALL_SRC] ? st_q.gen[1] : st_q.gen[0];
    end
    if (fall_in) begin
      st_d.fall_cnt = '0;
    end else if (dt_clk_en && st_q.fall_cnt < st_q.fall_act) begin
      st_d.fall_cnt = st_q.fall_cnt + 1'b1;
    end
    fall_o = (fall_in | (st_q.fall_cnt < st_q.fall_act)) ^
             st_q.dt_ctl[`PWO_F_FALL_POL];
    path_a = (st_q.dt_ctl[`PWO_F_SKIP_A] | st_q.dt_ctl[`PWO_F_DUAL_B])
             ? st_q.gen[0] : rise_o;
    path_b = st_q.dt_ctl[`PWO_F_SKIP_B] ? st_q.gen[1] : fall_o;
    dt_a = st_q.dt_ctl[`PWO_F_EXCH_A] ? path_b : path_a;
    dt_b = st_q.dt_ctl[`PWO_F_EXCH_B] ? path_a : path_b;

    // carrier: prescaler, eight-step phase, first pulse counters
    if (!st_q.car_ctl[`PWO_F_CH_EN] || ctick) begin
      st_d.div_cnt = 4'h0;
    end else begin
      st_d.div_cnt = st_q.div_cnt + 4'h1;
    end
    if (ctick) begin
      st_d.phase = st_q.phase + 3'h1;
    end
    cwave = {1'b0, st_q.phase} <
            {1'b0, st_q.car_ctl[`PWO_F_CH_DUTY]};
    cin_a = dt_a ^ st_q.car_ctl[`PWO_F_CH_IPOL];
    cin_b = dt_b ^ st_q.car_ctl[`PWO_F_CH_IPOL];
    if (!cin_a) begin
      st_d.first_a = 4'h0;
    end else if (ctick && st_q.first_a < st_q.car_ctl[`PWO_F_CH_FIRST]) begin
      st_d.first_a = st_q.first_a + 4'h1;
    end
    if (!cin_b) begin
      st_d.first_b = 4'h0;
    end else if (ctick && st_q.first_b < st_q.car_ctl[`PWO_F_CH_FIRST]) begin
      st_d.first_b = st_q.first_b + 4'h1;
    end
    ch_a = cin_a & ((st_q.first_a < st_q.car_ctl[`PWO_F_CH_FIRST]) | cwave);
    ch_b = cin_b & ((st_q.first_b < st_q.car_ctl[`PWO_F_CH_FIRST]) | cwave);
    if (st_q.car_ctl[`PWO_F_CH_EN]) begin
      st_d.outp = {ch_b, ch_a} ^ {2{st_q.car_ctl[`PWO_F_CH_OPOL]}};
    end else begin
      st_d.outp = {dt_b, dt_a};
    end
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  property p_oneshot_low;
    @(posedge ref_clk) disable iff (!rstn)
      (os_fire[0] && st_q.force_ctl[`PWO_F_OS_MODE_A] == 2'b01 &&
       st_q.hold_act[1:0] != 2'b01 && st_q.hold_act[1:0] != 2'b10)
      |=> (st_q.gen[0] == 1'b0);
  endproperty
  a_oneshot_low: assert property (p_oneshot_low)
    else $error("one-shot low force did not drive output A low");

  property p_hold_high;
    @(posedge ref_clk) disable iff (!rstn)
      (st_q.hold_act[3:2] == 2'b10) |=> st_q.gen[1];
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("continuous high force lost on output B");

  property p_hold_blocked;
    @(posedge ref_clk) disable iff (!rstn)
      st_q.force_ctl[5] |=> $stable(st_q.hold_act);
  endproperty
  a_hold_blocked: assert property (p_hold_blocked)
    else $error("continuous force changed while updates blocked");

  property p_rise_now;
    @(posedge ref_clk) disable iff (!rstn)
      (st_q.dt_ctl[`PWO_F_RISE_SEL] == 4'h0)
      |=> (st_q.rise_act == $past(st_q.rise_sh));
  endproperty
  a_rise_now: assert property (p_rise_now)
    else $error("rise delay did not load at once");

  property p_fall_held;
    @(posedge ref_clk) disable iff (!rstn)
      st_q.dt_ctl[3] |=> $stable(st_q.fall_act);
  endproperty
  a_fall_held: assert property (p_fall_held)
    else $error("fall delay changed while updates disabled");

  property p_up_zero_high;
    @(posedge ref_clk) disable iff (!rstn)
      (!timer_dir && ev == 6'b000001 && st_q.act_a[1:0] == 2'b10 &&
       os_fire == 2'b00 && st_q.hold_act == 4'h0)
      |=> st_q.gen[0];
  endproperty
  a_up_zero_high: assert property (p_up_zero_high)
    else $error("up-count zero action high not applied");

  property p_chop_bypass;
    @(posedge ref_clk) disable iff (!rstn)
      !st_q.car_ctl[`PWO_F_CH_EN] |=> (out_a == $past(dt_a));
  endproperty
  a_chop_bypass: assert property (p_chop_bypass)
    else $error("disabled carrier altered output A");

  property p_div_two;
    @(posedge ref_clk) disable iff (!rstn)
      (ctick && st_q.car_ctl[`PWO_F_CH_DIV] == 4'h1 &&
       !avs_write) |=> (!ctick ##1 ctick);
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("carrier clock period wrong for prescale 1");

  property p_dual_b;
    @(posedge ref_clk) disable iff (!rstn)
      (st_q.dt_ctl[`PWO_F_DUAL_B] && !st_q.dt_ctl[`PWO_F_EXCH_A] &&
       !st_q.car_ctl[`PWO_F_CH_EN]) |=> (out_a == $past(st_q.gen[0]));
  endproperty
  a_dual_b: assert property (p_dual_b)
    else $error("dual-edge mode delayed output A");

endmodule
`default_nettype wire

// ---- verification/pwo_gate_model.sv ----
// Purpose: gate driver pair model on the two PWM outputs
// Assumes: both gates on at once means shoot-through in a half bridge
// Notes:   counts overlap cycles for the bench to report
`timescale 1ns/100ps
`default_nettype none
module pwo_gate_model (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        out_a,
  input  wire logic        out_b,
  output logic      [15:0] overlap_cnt
);
  // count cycles with both gates driven on
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) overlap_cnt <= 16'h0000;
    else if (out_a && out_b) overlap_cnt <= overlap_cnt + 16'h0001;
  end
endmodule
`default_nettype wire

// ---- verification/tb_pwm_operator_output_stage.sv ----
// Purpose: self-checking bench of the operator output stage
// Assumes: one wait state per bus access, bounded waits anyway
// Notes:   random action codes, events, directions from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_pwm_operator_output_stage;
  import pwo_pkg::*;
  logic ref_clk, rstn, avs_read, avs_write, tick, dir, ea, eb, oa, ob;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, wd;
  logic        avs_waitrequest;
  logic [15:0] tv, tper, cma, cmb, ovl;
  logic        flt0, syn, dr;
  logic [1:0]  ca, cb;
  int          miscompares, checks, e, sh;
  logic [7:0]  ofs [8] = '{8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h60,
                           8'h64, 8'h6c};
  logic [31:0] msk [8] = '{32'hffff, 32'hffffff, 32'hffffff, 32'h3ffff,
                           32'hffff, 32'hffff, 32'h3fff, 32'h0};
  pwo_output_stage dut (.ref_clk(ref_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer_tick_en(tick),
    .timer_dir(dir), .timer_value(tv), .timer_period(tper),
    .cmp_a_value(cma), .cmp_b_value(cmb), .evt_sync(syn),
    .fault_input_0(flt0), .fault_input_1(1'b0),
    .fault_input_2(1'b0), .out_a(oa), .out_b(ob));
  pwo_gate_model gates (.ref_clk(ref_clk), .rstn(rstn), .out_a(oa),
    .out_b(ob), .overlap_cnt(ovl));
  // free running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // next level for one action code
  function automatic logic lv(input logic o, input logic [1:0] c);
    return (c == 2'h0) ? o : (c == 2'h1) ? 1'b0 : (c == 2'h2) ? 1'b1 : ~o;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one bus access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so the next call never retimes the strobe
    @(posedge ref_clk);
    if (n >= 50) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // one timer step carrying event e (4 fault 0 on aux 0, 5 sync on aux 1)
  task automatic ev(input int k, input logic d);
    tick <= 1'b1;
    dir <= d;
    tv <= (k == 0) ? 16'h0 : (k == 1) ? tper : (k == 2) ? cma :
          (k == 3) ? cmb : 16'hfff0;
    flt0 <= (k == 4);
    syn <= (k == 5);
    @(posedge ref_clk);
    tick <= 1'b0;
    tv <= 16'hfff0;
    flt0 <= 1'b0;
    syn <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  initial begin
    void'($urandom(32'he267fc58));
    {rstn, avs_read, avs_write, tick, dir, flt0, syn} = '0;
    {avs_address, avs_writedata} = '0;
    tv = 16'hfff0;
    tper = 16'h0300 | 16'($urandom() % 256);
    cma = 16'h0100 | 16'($urandom() % 256);
    cmb = 16'h0200 | 16'($urandom() % 256);
    miscompares = 0;
    checks = 0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // register readback, unmapped place reads zero
    for (int i = 0; i < 8; i++) begin
      wd = $urandom();
      bus(1'b1, ofs[i], wd);
      bus(1'b0, ofs[i], 32'h0);
      `CHK("reg", wd & msk[i], q)
    end
    $display("test regs done");
    // action tables: random event, direction and codes, bypassed dead time
    bus(1'b1, 8'h58, 32'h18000);
    bus(1'b1, 8'h64, 32'h0);
    bus(1'b1, 8'h4c, 32'h0);
    // aux 0 from fault 0, aux 1 from sync, so each event has one field
    bus(1'b1, 8'h48, 32'h18);
    for (int i = 0; i < 16; i++) begin
      e = $urandom() % 6;
      dr = $urandom() % 2;
      ca = (i == 0) ? 2'h1 : 2'($urandom());
      cb = (i == 0) ? 2'h1 : 2'($urandom());
      sh = 2 * e + 12 * dr;
      bus(1'b1, 8'h50, 32'(ca) << sh);
      bus(1'b1, 8'h54, 32'(cb) << sh);
      ev(e, dr);
      ea = lv(ea, ca);
      eb = lv(eb, cb);
      `CHK("out_a", ea, oa)
      `CHK("out_b", eb, ob)
    end
    $display("test actions done");
    // continuous force beats the action table, then one-shot both ways
    bus(1'b1, 8'h50, 32'h1);
    bus(1'b1, 8'h4c, 32'h80);
    ev(0, 1'b0);
    `CHK("hold_a", 1'b1, oa)
    bus(1'b1, 8'h4c, 32'h0);
    bus(1'b1, 8'h4c, 32'h0c00);
    repeat (4) @(posedge ref_clk);
    `CHK("shot_lo", 1'b0, oa)
    bus(1'b1, 8'h4c, 32'h1000);
    repeat (4) @(posedge ref_clk);
    `CHK("shot_hi", 1'b1, oa)
    $display("test force done");
    // delay writes stay in shadows while update is disabled
    bus(1'b1, 8'h5c, 32'h00bb);
    bus(1'b1, 8'h60, 32'h00aa);
    bus(1'b1, 8'h58, 32'h18088);
    bus(1'b1, 8'h5c, 32'h5678);
    bus(1'b1, 8'h60, 32'h1234);
    bus(1'b0, 8'h74, 32'h0);
    `CHK("dly_old", 32'h00aa00bb, q)
    bus(1'b1, 8'h58, 32'h18000);
    repeat (2) @(posedge ref_clk);
    bus(1'b0, 8'h74, 32'h0);
    `CHK("dly_new", 32'h12345678, q)
    $display("test delays done, overlap %0d", ovl);
    // both delays on, B inverted: the gates are never on together
    bus(1'b1, 8'h5c, 32'h8);
    bus(1'b1, 8'h60, 32'h8);
    bus(1'b1, 8'h58, 32'h4000);
    repeat (4) @(posedge ref_clk);
    sh = ovl;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h4c, i[0] ? 32'h1000 : 32'h0c00);
      repeat (20) @(posedge ref_clk);
    end
    `CHK("overlap", 16'(sh), ovl)
    `CHK("dt_a", 1'b1, oa)
    `CHK("dt_b", 1'b0, ob)
    // carrier at prescale 1: high cycles over four carrier periods
    sh = $urandom() % 8;
    bus(1'b1, 8'h64, 32'h3 | (32'(sh) << 5));
    repeat (8) @(posedge ref_clk);
    e = 0;
    repeat (64) begin
      @(posedge ref_clk);
      e += (oa === 1'b1);
    end
    `CHK("duty", 8 * sh, e)
    $display("test dead time and carrier done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
